/* File: panel_pkg.sv */
// Constants for the operator panel interface card.
// Assumes a single 100 MHz clock domain.
package panel_pkg;
    localparam int SYS_W        = 18;
    localparam int CMD_W        = 4;
    localparam int LVL_W        = 3;
    localparam int KEY_W        = 5;
    localparam int PDAT_W       = 4;
    localparam int SEL_W        = 3;
    localparam int NKEYS        = 32;
    localparam logic [3:0] MODE_POWER_OFF = 4'h6;
    // Select bus codes: four display characters, two LED groups
    localparam logic [2:0] SEL_HEX0 = 3'h0;
    localparam logic [2:0] SEL_LED0 = 3'h4;
    localparam logic [2:0] SEL_LED1 = 3'h5;
    // Processor control bus command codes
    localparam logic [3:0] CMD_NONE  = 4'h0;
    localparam logic [3:0] CMD_START = 4'h1;
    localparam logic [3:0] CMD_STOP  = 4'h2;
    localparam logic [3:0] CMD_RESET = 4'h4;
    // Timing: settle and strobe widths in ns, converted to cycles
    localparam int CLK_NS       = 10;
    localparam int SETUP_NS     = 20;
    localparam int STROBE_NS    = 20;
    localparam int SETUP_CYC    = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W        = 4;
endpackage : panel_pkg

/* File: operator_panel_interface.sv */
// Operator panel interface card: processor side and panel side.
// Assumes all inputs except the async rstn synchronous to ref_clk; no register bus.
`timescale 1ns/1ps

// Contract
// - Shared 18-bit bidirectional system bus
// - Four-signal control bus carries start/stop/reset
// - Separate strobe qualifies each control command
// - Key address selects key; panel reports pressed
// - Panel bus carries hex, LED, or line-select
// - Degate segments blocks display, LEDs take data
// - Power key in mode 6 requests power off
// - I/O immediate also requests power off
// - Panel strobe pulses only on stable data
// - Select bus picks hex character or LED group
// - Storage display/alter only while unlocked
module operator_panel_interface (
    input  wire logic                        ref_clk,
    input  wire logic                        rstn,
    // System bus, split into three signals
    input  wire logic [panel_pkg::SYS_W-1:0] sysBusIn,
    output logic      [panel_pkg::SYS_W-1:0] sysBusOut,
    output logic                             sysBusOe,
    // Processor control bus
    output logic      [panel_pkg::CMD_W-1:0] processorControlBusN,
    output logic                             controlBusStrobeN,
    input  wire logic [panel_pkg::LVL_W-1:0] operatingLevelBitsN,
    input  wire logic                        processorCheckN,
    input  wire logic                        processorRunningN,
    input  wire logic                        processorCheckFlagN,
    // Panel side
    output logic      [panel_pkg::KEY_W-1:0] keyAddress,
    input  wire logic                        keyPressedN,
    input  wire logic [panel_pkg::PDAT_W-1:0] panelDataBusInN,
    output logic      [panel_pkg::PDAT_W-1:0] panelDataBusOutN,
    output logic                             panelDataBusOe,
    output logic                             degateSegments,
    output logic                             lampTestN,
    input  wire logic                        powerKeyN,
    output logic                             powerOffN,
    output logic                             panelStrobeN,
    output logic      [panel_pkg::SEL_W-1:0] selectBus,
    input  wire logic                        storageUnlockN,
    // User side: commands and data for the card's own control logic
    input  wire logic                        cmdValid,
    input  wire logic [panel_pkg::CMD_W-1:0] cmdCode,
    output logic                             cmdReady,
    input  wire logic                        panelWrValid,
    input  wire logic [panel_pkg::SEL_W-1:0] panelWrSel,
    input  wire logic [panel_pkg::PDAT_W-1:0] panelWrData,
    output logic                             panelWrReady,
    input  wire logic                        lampTestReq,
    input  wire logic                        commSelectRd,
    input  wire logic [3:0]                  panelMode,
    input  wire logic                        ioPowerOff,
    input  wire logic                        storeReq,
    input  wire logic [panel_pkg::SYS_W-1:0] storeData,
    output logic                             storeAccepted,
    output logic      [panel_pkg::SYS_W-1:0] sysBusCapture,
    output logic [panel_pkg::NKEYS-1:0]      keyState,
    output logic [panel_pkg::PDAT_W-1:0]     commLineSelect,
    output logic [panel_pkg::LVL_W-1:0]      operatingLevel,
    output logic                             processorCheck,
    output logic                             processorRunning,
    output logic                             checkSeen
);
    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [1:0] {PS_IDLE, PS_SETUP, PS_STROBE} phase_e;

    typedef struct packed {
        phase_e                        cmdPh;
        logic [panel_pkg::CNT_W-1:0]   cmdCnt;
        logic [panel_pkg::CMD_W-1:0]   cmd;
        phase_e                        pnlPh;
        logic [panel_pkg::CNT_W-1:0]   pnlCnt;
        logic [panel_pkg::SEL_W-1:0]   sel;
        logic [panel_pkg::PDAT_W-1:0]  pdat;
        logic                          degate;
        logic [panel_pkg::KEY_W-1:0]   keyAdr;
        logic [panel_pkg::NKEYS-1:0]   keys;
        logic [panel_pkg::PDAT_W-1:0]  comm;
        logic                          ioOff;
        logic                          powerOff;
        logic                          lamp;
        logic [panel_pkg::SYS_W-1:0]   sysOut;
        logic                          sysOe;
        logic [panel_pkg::SYS_W-1:0]   sysCap;
        logic                          storeAcc;
        logic [panel_pkg::LVL_W-1:0]   level;
        logic                          run;
        logic                          pchk;
        logic                          chk;
    } state_s;

    state_s stateQ;
    state_s stateD;
    logic   keyPressed;
    logic   unlocked;

    assign keyPressed = ~keyPressedN;
    assign unlocked   = ~storageUnlockN;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        stateD          = stateQ;
        stateD.storeAcc = 1'b0;
        // Processor status is sampled every cycle
        stateD.level = ~operatingLevelBitsN;
        stateD.run   = ~processorRunningN;
        stateD.pchk  = ~processorCheckN;
        // Check pulse is at least 100 ns, so one sample suffices
        if (~processorCheckFlagN) begin
            stateD.chk = 1'b1;
        end

        // Control bus: settle, strobe, then release
        case (stateQ.cmdPh)
            PS_IDLE: begin
                if (cmdValid) begin
                    stateD.cmd    = cmdCode;
                    stateD.cmdCnt = '0;
                    stateD.cmdPh  = PS_SETUP;
                end
            end
            PS_SETUP: begin
                stateD.cmdCnt = stateQ.cmdCnt + 1'b1;
                if (stateQ.cmdCnt ==
                    panel_pkg::CNT_W'(panel_pkg::SETUP_CYC - 1)) begin
                    stateD.cmdCnt = '0;
                    stateD.cmdPh  = PS_STROBE;
                end
            end
            PS_STROBE: begin
                stateD.cmdCnt = stateQ.cmdCnt + 1'b1;
                if (stateQ.cmdCnt ==
                    panel_pkg::CNT_W'(panel_pkg::STROBE_CYC - 1)) begin
                    stateD.cmd   = panel_pkg::CMD_NONE;
                    stateD.cmdPh = PS_IDLE;
                end
            end
            default: stateD.cmdPh = PS_IDLE;
        endcase

        // Panel latch write: data and select settle before strobe
        case (stateQ.pnlPh)
            PS_IDLE: begin
                if (panelWrValid) begin
                    stateD.sel    = panelWrSel;
                    stateD.pdat   = panelWrData;
                    // LED groups need the display degated
                    stateD.degate = (panelWrSel == panel_pkg::SEL_LED0) ||
                                    (panelWrSel == panel_pkg::SEL_LED1);
                    stateD.pnlCnt = '0;
                    stateD.pnlPh  = PS_SETUP;
                end
            end
            PS_SETUP: begin
                stateD.pnlCnt = stateQ.pnlCnt + 1'b1;
                if (stateQ.pnlCnt ==
                    panel_pkg::CNT_W'(panel_pkg::SETUP_CYC - 1)) begin
                    stateD.pnlCnt = '0;
                    stateD.pnlPh  = PS_STROBE;
                end
            end
            PS_STROBE: begin
                stateD.pnlCnt = stateQ.pnlCnt + 1'b1;
                if (stateQ.pnlCnt ==
                    panel_pkg::CNT_W'(panel_pkg::STROBE_CYC - 1)) begin
                    stateD.pnlPh  = PS_IDLE;
                    stateD.degate = 1'b0;
                end
            end
            default: stateD.pnlPh = PS_IDLE;
        endcase

        // Key scan: one key per cycle, result stored by address
        stateD.keyAdr = stateQ.keyAdr + 1'b1;
        stateD.keys[stateQ.keyAdr] = keyPressed;

        // Line select read only while the panel bus is not driven
        if (commSelectRd && stateQ.pnlPh == PS_IDLE) begin
            stateD.comm = ~panelDataBusInN;
        end

        stateD.lamp = lampTestReq;
        if (ioPowerOff) begin
            stateD.ioOff = 1'b1;
        end
        stateD.powerOff = stateQ.ioOff ||
            (~powerKeyN && panelMode == panel_pkg::MODE_POWER_OFF);

        // Storage alter from the panel is gated by unlock
        stateD.sysOe = 1'b0;
        if (storeReq && unlocked) begin
            stateD.sysOut   = storeData;
            stateD.sysOe    = 1'b1;
            stateD.storeAcc = 1'b1;
        end else if (unlocked) begin
            stateD.sysCap = sysBusIn;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            stateQ <= '{cmdPh: PS_IDLE, pnlPh: PS_IDLE, default: '0};
        end else begin
            stateQ <= stateD;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign cmdReady             = (stateQ.cmdPh == PS_IDLE);
    assign panelWrReady         = (stateQ.pnlPh == PS_IDLE);
    assign processorControlBusN = ~stateQ.cmd;
    // Strobe only after the command has settled
    assign controlBusStrobeN = ~(stateQ.cmdPh == PS_STROBE);
    assign panelStrobeN      = ~(stateQ.pnlPh == PS_STROBE);
    assign panelDataBusOutN  = ~stateQ.pdat;
    assign panelDataBusOe    = (stateQ.pnlPh != PS_IDLE);
    assign selectBus         = stateQ.sel;
    assign degateSegments    = stateQ.degate;
    assign keyAddress        = stateQ.keyAdr;
    assign lampTestN         = ~stateQ.lamp;
    assign powerOffN         = ~stateQ.powerOff;
    assign sysBusOut         = stateQ.sysOut;
    assign sysBusOe          = stateQ.sysOe;
    assign storeAccepted     = stateQ.storeAcc;
    assign sysBusCapture     = stateQ.sysCap;
    assign keyState          = stateQ.keys;
    assign commLineSelect    = stateQ.comm;
    assign operatingLevel    = stateQ.level;
    assign processorCheck    = stateQ.pchk;
    assign processorRunning  = stateQ.run;
    assign checkSeen         = stateQ.chk;
endmodule : operator_panel_interface

/* File: operator_panel_interface_sva.sv */
// Port checker for the operator panel interface card.
// Assumes one clock, ref_clk, and async active-low rstn.
`timescale 1ns/1ps
module panel_checker (
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        cmdValid,
    input wire logic        cmdReady,
    input wire logic [3:0]  cmdCode,
    input wire logic [3:0]  processorControlBusN,
    input wire logic        controlBusStrobeN,
    input wire logic [2:0]  panelWrSel,
    input wire logic        panelStrobeN,
    input wire logic [3:0]  panelDataBusOutN,
    input wire logic        panelDataBusOe,
    input wire logic [2:0]  selectBus,
    input wire logic        degateSegments,
    input wire logic        storeReq,
    input wire logic [17:0] storeData,
    input wire logic        storageUnlockN,
    input wire logic        storeAccepted,
    input wire logic        sysBusOe,
    input wire logic [17:0] sysBusOut,
    input wire logic        powerKeyN,
    input wire logic [3:0]  panelMode,
    input wire logic        powerOffN,
    input wire logic [4:0]  keyAddress
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_cmd_strobe: assert property (cmdValid && cmdReady |=>
        controlBusStrobeN[*2] ##1 !controlBusStrobeN[*2] ##1 controlBusStrobeN)
        else $error("control strobe timing wrong");
    a_cmd_value: assert property ($fell(controlBusStrobeN) |->
        processorControlBusN == ~$past(cmdCode, 3)) else $error("bad command");
    a_strobe_stable: assert property (!panelStrobeN |->
        panelDataBusOe && $stable(panelDataBusOutN)) else $error("data moved");
    a_degate_led: assert property (!panelStrobeN |->
        degateSegments == selectBus[2]) else $error("degate wrong");
    a_select_dest: assert property ($fell(panelStrobeN) |->
        selectBus == $past(panelWrSel, 3)) else $error("select wrong");
    a_store_lock: assert property (storeAccepted |-> sysBusOe &&
        $past(storeReq && !storageUnlockN) && sysBusOut == $past(storeData))
        else $error("store while locked or bad data");
    a_power_key: assert property (!powerKeyN && panelMode == 4'h6
        |=> !powerOffN) else $error("power off not requested");
    // Both samples must be out of reset, or a mid-run release looks like a skip
    a_key_scan: assert property (rstn && $past(rstn) |->
        keyAddress == 5'($past(keyAddress) + 5'h01)) else $error("key scan");
endmodule : panel_checker

bind operator_panel_interface panel_checker chk (.*);

/* File: panel_model.sv */
// Behavioural front panel: key matrix, panel latches, line select source.
// Assumes the card drives the panel bus only while panelDataBusOe is high.
`timescale 1ns/1ps
module panel_model (
    input  wire logic [4:0]  keyAddress,
    input  wire logic [31:0] pressedMask,
    output logic             keyPressedN,
    input  wire logic [3:0]  panelDataBusOutN,
    input  wire logic        panelDataBusOe,
    input  wire logic [3:0]  commData,
    output logic      [3:0]  panelDataBusInN,
    input  wire logic        panelStrobeN,
    input  wire logic [2:0]  selectBus,
    input  wire logic        lampTestN,
    output logic      [3:0]  capData,
    output logic      [2:0]  capSel,
    output logic             lampOn
);
    assign keyPressedN = ~pressedMask[keyAddress];
    // Panel drives line select whenever the card lets go of the bus
    assign panelDataBusInN = panelDataBusOe ? panelDataBusOutN : ~commData;
    assign lampOn = ~lampTestN;
    // Latch on the leading edge: data must already be settled
    always @(negedge panelStrobeN) begin
        capData <= ~panelDataBusInN;
        capSel  <= selectBus;
    end
endmodule : panel_model

/* File: operator_panel_interface_tb.sv */
// Self-checking bench for the operator panel interface card.
// Assumes panel_model stands on the panel side; processor side is driven here.
`timescale 1ns/1ps
module operator_panel_interface_tb;
    logic ref_clk = 1'b0, rstn = 1'b0, processorCheckN = 1'b1;
    logic processorRunningN = 1'b1, processorCheckFlagN = 1'b1;
    logic powerKeyN = 1'b1, storageUnlockN = 1'b1, cmdValid = 1'b0;
    logic panelWrValid = 1'b0, lampTestReq = 1'b0, commSelectRd = 1'b0;
    logic ioPowerOff = 1'b0, storeReq = 1'b0;
    logic sysBusOe, controlBusStrobeN, keyPressedN, panelDataBusOe, lampOn;
    logic degateSegments, lampTestN, powerOffN, panelStrobeN, cmdReady;
    logic panelWrReady, storeAccepted, processorCheck, processorRunning;
    logic checkSeen;
    logic [17:0] sysBusIn = '0, storeData = '0, sysBusOut, sysBusCapture;
    logic [3:0] cmdCode = '0, panelWrData = '0, panelMode = '0, commData = '0;
    logic [3:0] processorControlBusN, panelDataBusInN, panelDataBusOutN;
    logic [3:0] commLineSelect, capData;
    logic [2:0] operatingLevelBitsN = 3'h7, panelWrSel = '0, selectBus, capSel;
    logic [2:0] operatingLevel;
    logic [4:0] keyAddress;
    logic [31:0] keyState, pressedMask = '0;
    int err_count = 0, checked = 0, cycles = 0;
    operator_panel_interface uut (.*);
    panel_model far (.*);
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude
    // Hang guard: every scenario together needs well under this
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            conclude();
        end
    end
    task automatic cmp(input logic [31:0] got, exp, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : cmp
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic await(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 50) begin
            tick(1);
            n++;
        end
        cmp(32'(s), 32'(v), "handshake wait");
    endtask : await
    task automatic t_reset();
        cmp({cmdReady, controlBusStrobeN, panelStrobeN, powerOffN}, 4'hF,
            "idle levels");
        cmp({sysBusOe, panelDataBusOe, checkSeen}, 3'h0, "idle enables");
    endtask : t_reset
    task automatic t_cmd();
        logic [3:0] codes [3] = '{panel_pkg::CMD_START, panel_pkg::CMD_STOP,
                                  panel_pkg::CMD_RESET};
        foreach (codes[i]) begin
            @(posedge ref_clk);
            cmdValid <= 1'b1;
            cmdCode  <= codes[i];
            @(posedge ref_clk);
            cmdValid <= 1'b0;
            #1;
            await(controlBusStrobeN, 1'b0);
            cmp(32'(processorControlBusN), 32'(4'(~codes[i])), "command");
            await(cmdReady, 1'b1);
        end
    endtask : t_cmd
    task automatic t_panel();
        logic [2:0] sels [3] = '{3'h0, 3'h4, 3'h5};
        foreach (sels[i]) begin
            @(posedge ref_clk);
            panelWrValid <= 1'b1;
            panelWrSel   <= sels[i];
            panelWrData  <= 4'h3 + 4'(i) * 4'h3;
            @(posedge ref_clk);
            panelWrValid <= 1'b0;
            #1;
            await(panelStrobeN, 1'b0);
            cmp(32'(degateSegments), 32'(sels[i] >= panel_pkg::SEL_LED0),
                "degate");
            await(panelWrReady, 1'b1);
            cmp(32'(capSel), 32'(sels[i]), "select");
            cmp(32'(capData), 32'(4'h3 + 4'(i) * 4'h3), "panel data");
        end
    endtask : t_panel
    task automatic t_status();
        @(posedge ref_clk);
        lampTestReq <= 1'b1;
        commSelectRd <= 1'b1;
        commData <= 4'hA;
        operatingLevelBitsN <= 3'h2;
        processorRunningN <= 1'b0;
        processorCheckN <= 1'b0;
        processorCheckFlagN <= 1'b0;
        storageUnlockN <= 1'b0;
        sysBusIn <= 18'h2A5C3;
        pressedMask <= 32'h80000011;
        repeat (10) @(posedge ref_clk);
        processorCheckFlagN <= 1'b1;
        tick(40);
        cmp(32'(lampOn), 32'h1, "lamp test");
        cmp(32'(commLineSelect), 32'hA, "line select");
        cmp(32'(operatingLevel), 32'h5, "level");
        cmp({processorRunning, processorCheck}, 2'h3, "run and check");
        cmp(32'(checkSeen), 32'h1, "check pulse");
        cmp(32'(sysBusCapture), 32'h2A5C3, "bus capture");
        cmp(keyState, 32'h80000011, "keys");
    endtask : t_status
    task automatic t_store();
        @(posedge ref_clk);
        storageUnlockN <= 1'b1;
        storeReq <= 1'b1;
        storeData <= 18'h1F0E1;
        tick(3);
        cmp({storeAccepted, sysBusOe}, 2'h0, "locked store");
        @(posedge ref_clk);
        storageUnlockN <= 1'b0;
        @(posedge ref_clk);
        storeReq <= 1'b0;
        #1;
        await(storeAccepted, 1'b1);
        cmp(32'(sysBusOut), 32'h1F0E1, "store data");
    endtask : t_store
    task automatic t_power();
        @(posedge ref_clk);
        powerKeyN <= 1'b0;
        panelMode <= 4'h5;
        tick(3);
        cmp(32'(powerOffN), 32'h1, "mode 5 key");
        @(posedge ref_clk);
        panelMode <= panel_pkg::MODE_POWER_OFF;
        tick(2);
        cmp(32'(powerOffN), 32'h0, "mode 6 key");
        @(posedge ref_clk);
        powerKeyN <= 1'b1;
        rstn <= 1'b0;
        @(posedge ref_clk);
        rstn <= 1'b1;
        tick(2);
        cmp(32'(powerOffN), 32'h1, "after reset");
        cmp(32'(checkSeen), 32'h0, "check cleared by reset");
        @(posedge ref_clk);
        ioPowerOff <= 1'b1;
        @(posedge ref_clk);
        ioPowerOff <= 1'b0;
        tick(3);
        cmp(32'(powerOffN), 32'h0, "io power off");
    endtask : t_power
    initial begin
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        tick(1);
        t_reset();
        t_cmd();
        t_panel();
        t_status();
        t_store();
        t_power();
        conclude();
    end
endmodule : operator_panel_interface_tb
